//--- core/qsp_pkg.sv
// Purpose: Shared constants and types for the quad serial flash pin interface.
// Assumes: Lane mode codes are set by the command core before a frame starts.
// Notes:   No software-visible registers; every value here but the idle byte and QSP_LINE_W sizes logic or codes modes.
package qsp_pkg;

  localparam int unsigned QSP_BYTE_W     = 8;
  localparam int unsigned QSP_LINE_W     = 4;
  localparam int unsigned QSP_FIFO_DEPTH = 4;

  // Lane mode codes driven on lane_mode
  localparam logic [1:0] QSP_MODE_SINGLE          = 2'h0;
  localparam logic [1:0] QSP_MODE_DUAL            = 2'h1;
  localparam logic [1:0] QSP_QUAD_IO_MODE         = 2'h2;
  localparam logic [1:0] QSP_QUAD_PERIPHERAL_MODE = 2'h3;

  // Output enable patterns per lane mode
  localparam logic [3:0] QSP_OE_SINGLE = 4'h2;
  localparam logic [3:0] QSP_OE_DUAL   = 4'h3;
  localparam logic [3:0] QSP_OE_QUAD   = 4'hF;
  localparam logic [3:0] QSP_OE_NONE   = 4'h0;

  // Bits moved per serial clock cycle
  localparam logic [3:0] QSP_STEP_SINGLE = 4'h1;
  localparam logic [3:0] QSP_STEP_DUAL   = 4'h2;
  localparam logic [3:0] QSP_STEP_QUAD   = 4'h4;
  localparam logic [3:0] QSP_STEP_DDR    = 4'h8;

  // Byte sent when the core has nothing queued
  localparam logic [7:0] QSP_IDLE_BYTE = 8'hFF;

  // Hardware reset sequencing
  typedef enum logic [1:0] {
    QSP_RST_IDLE,
    QSP_RST_HELD,
    QSP_RST_RECOVER
  } qsp_rst_e;

endpackage

//--- core/qsp_sync.sv
// Purpose: Two-flop synchroniser for a group of independent levels.
// Assumes: Each bit is a level or a toggle; no bit group needs coherence.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/10ps
module qsp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // qsp_sync

//--- core/qsp_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   flush empties it in one cycle; a push in that cycle is dropped.
`timescale 1ns/10ps
module qsp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule // qsp_fifo

//--- core/qsp_pin_if.sv
// Purpose: Device-side pin logic of a quad serial flash host interface.
// Assumes: Lane mode, DDR request and read phase settle before the frame's first edge.
// Notes:   Link logic runs on serial_clock; the core side runs on sys_clk.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module qsp_pin_if (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Pins
  input  wire logic       serial_clock,
  input  wire logic       dev_sel_n,
  input  wire logic [3:0] io_line_in,
  output logic      [3:0] io_line_out,
  output logic      [3:0] io_line_oe,
  input  wire logic       reset_pin_n,
  // Core configuration and status
  input  wire logic [1:0] lane_mode,
  input  wire logic       ddr_req,
  input  wire logic       read_phase,
  input  wire logic       dq3_reset_en,
  input  wire logic       embedded_busy,
  // Received bytes
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  // Bytes to send
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  // Status
  output logic            dev_active,
  output logic            frame_start,
  output logic            frame_end,
  output logic            write_protect_n,
  output logic            hw_reset,
  output logic            array_read
);
  import qsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Link-domain reset
  logic       quad_l;
  logic       ddr_l;
  logic       out_l;
  logic [1:0] mode_l;
  logic       ddr_req_l;
  logic       read_l;
  logic       pin_reset_now;
  logic       link_rst_n;

  // Line 3 acts as reset only outside quad frames
  assign pin_reset_now = !reset_pin_n
                       || (dq3_reset_en && !io_line_in[3] && (dev_sel_n || !quad_l));
  // Select high or reset parks the link shift state and floats the lines; toggles, ack and output flops hold
  assign link_rst_n = arst_n && !dev_sel_n && !pin_reset_now;

  qsp_sync #(.W(4)) u_cfg_sync (
    .clk   (serial_clock),
    .rst_n (arst_n),
    .d     ({lane_mode, ddr_req, read_phase}),
    .q     ({mode_l, ddr_req_l, read_l})
  );

  assign quad_l = mode_l[1];
  assign ddr_l  = quad_l && ddr_req_l;
  assign out_l  = read_l;

  ////////////////////////////////////////////////////////////////////////////////
  // Receive, rising edge
  logic [7:0] rx_sh_r;
  logic [3:0] rx_cnt_r;
  logic [3:0] hi_nib_r;
  logic [7:0] sdr_buf_r [2];
  logic       sdr_tgl_r;
  logic [7:0] rx_sh_nxt;
  logic [3:0] rx_step;

  always_comb begin
    case (mode_l)
      QSP_MODE_SINGLE: begin
        rx_sh_nxt = {rx_sh_r[6:0], io_line_in[0]};
        rx_step   = QSP_STEP_SINGLE;
      end
      QSP_MODE_DUAL: begin
        rx_sh_nxt = {rx_sh_r[5:0], io_line_in[1:0]};
        rx_step   = QSP_STEP_DUAL;
      end
      default: begin
        rx_sh_nxt = {rx_sh_r[3:0], io_line_in};
        rx_step   = QSP_STEP_QUAD;
      end
    endcase
  end

  // Inputs taken on rising edges: the whole byte in SDR, the high nibble in DDR
  always_ff @(posedge serial_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rx_sh_r   <= '0;
      rx_cnt_r  <= '0;
      hi_nib_r  <= '0;
    end else if (!out_l) begin
      if (ddr_l) begin
        hi_nib_r <= io_line_in;
      end else begin
        rx_sh_r <= rx_sh_nxt;
        if (rx_cnt_r + rx_step == QSP_STEP_DDR) begin
          rx_cnt_r  <= '0;
        end else begin
          rx_cnt_r <= rx_cnt_r + rx_step;
        end
      end
    end
  end

  // Toggles keep their level across deselect; a cleared one would read as a new byte
  always_ff @(posedge serial_clock or negedge arst_n) begin
    if (!arst_n) begin
      sdr_tgl_r <= 1'b0;
    end else if (link_rst_n && !out_l && !ddr_l && (rx_cnt_r + rx_step == QSP_STEP_DDR)) begin
      sdr_tgl_r <= !sdr_tgl_r;
    end
  end

  // Ping-pong so a byte stays still while the toggle crosses
  always_ff @(posedge serial_clock) begin
    if (link_rst_n && !out_l && !ddr_l && (rx_cnt_r + rx_step == QSP_STEP_DDR)) begin
      sdr_buf_r[!sdr_tgl_r] <= rx_sh_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive, falling edge (DDR)
  logic [7:0] ddr_buf_r [2];
  logic       ddr_tgl_r;

  always_ff @(negedge serial_clock or negedge arst_n) begin
    if (!arst_n) begin
      ddr_tgl_r <= 1'b0;
    end else if (link_rst_n && !out_l && ddr_l) begin
      ddr_tgl_r <= !ddr_tgl_r;
    end
  end

  always_ff @(negedge serial_clock) begin
    if (link_rst_n && !out_l && ddr_l) begin
      ddr_buf_r[!ddr_tgl_r] <= {hi_nib_r, io_line_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit, falling edge launches; DDR adds the rising edge
  logic [7:0] tx_hold_r;
  logic       tx_req_r;
  logic       tx_req_l;
  logic       tx_ack_r;
  logic [7:0] tx_sh_r;
  logic [3:0] tx_cnt_r;
  logic [3:0] lo_nib_r;
  logic [3:0] q_neg_r;
  logic [3:0] q_pos_r;
  logic [3:0] oe_r;
  logic [7:0] tx_byte;
  logic       tx_have;
  logic [3:0] tx_step;
  logic [3:0] tx_chunk;
  logic [3:0] oe_nxt;

  qsp_sync #(.W(1)) u_req_sync (
    .clk   (serial_clock),
    .rst_n (arst_n),
    .d     (tx_req_r),
    .q     (tx_req_l)
  );

  assign tx_have = (tx_req_l != tx_ack_r);
  assign tx_byte = (tx_cnt_r != '0) ? tx_sh_r : (tx_have ? tx_hold_r : QSP_IDLE_BYTE);

  always_comb begin
    case (mode_l)
      QSP_MODE_SINGLE: begin
        tx_chunk = {2'h0, tx_byte[7], 1'b0};
        tx_step  = QSP_STEP_SINGLE;
        oe_nxt   = QSP_OE_SINGLE;
      end
      QSP_MODE_DUAL: begin
        tx_chunk = {2'h0, tx_byte[7:6]};
        tx_step  = QSP_STEP_DUAL;
        oe_nxt   = QSP_OE_DUAL;
      end
      default: begin
        tx_chunk = tx_byte[7:4];
        tx_step  = ddr_l ? QSP_STEP_DDR : QSP_STEP_QUAD;
        oe_nxt   = QSP_OE_QUAD;
      end
    endcase
  end

  // Ack lives in the link domain; a missing byte sends the idle pattern
  always_ff @(negedge serial_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_sh_r  <= '0;
      tx_cnt_r <= '0;
      lo_nib_r <= '0;
      oe_r     <= QSP_OE_NONE;
    end else if (out_l) begin
      oe_r     <= oe_nxt;
      tx_sh_r  <= tx_byte << tx_step;
      lo_nib_r <= tx_byte[3:0];
      if (tx_cnt_r + tx_step == QSP_STEP_DDR) begin
        tx_cnt_r <= '0;
      end else begin
        tx_cnt_r <= tx_cnt_r + tx_step;
      end
    end else begin
      oe_r <= QSP_OE_NONE;
    end
  end

  // Ack must survive select-high so a byte is never taken twice
  always_ff @(negedge serial_clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_ack_r <= 1'b0;
    end else if (link_rst_n && out_l && tx_cnt_r == '0 && tx_have) begin
      tx_ack_r <= tx_req_l;
    end
  end

  // Dual-edge output: pin value is the XOR of a falling and a rising flop
  always_ff @(negedge serial_clock or negedge arst_n) begin
    if (!arst_n) begin
      q_neg_r <= '0;
    end else if (link_rst_n && out_l) begin
      q_neg_r <= tx_chunk ^ q_pos_r;
    end
  end

  always_ff @(posedge serial_clock or negedge arst_n) begin
    if (!arst_n) begin
      q_pos_r <= '0;
    end else if (link_rst_n && out_l && ddr_l) begin
      q_pos_r <= lo_nib_r ^ q_neg_r;
    end
  end

  assign io_line_out = q_pos_r ^ q_neg_r;
  assign io_line_oe  = oe_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Core-side synchronisers
  logic sel_s;
  logic rst_low_s;
  logic line3_low_s;
  logic line2_low_s;
  logic sdr_tgl_s;
  logic ddr_tgl_s;
  logic ack_s;

  // Low-active pins enter inverted so a cleared synchroniser reads idle
  qsp_sync #(.W(7)) u_pin_sync (
    .clk   (sys_clk),
    .rst_n (arst_n),
    .d     ({!dev_sel_n, !reset_pin_n, !io_line_in[3], !io_line_in[2],
             sdr_tgl_r, ddr_tgl_r, tx_ack_r}),
    .q     ({sel_s, rst_low_s, line3_low_s, line2_low_s, sdr_tgl_s, ddr_tgl_s, ack_s})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Framing and power state
  logic sel_d_r;
  logic dev_active_r;
  logic frame_start_r;
  logic frame_end_r;
  logic wp_n_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_d_r       <= 1'b0;
      frame_start_r <= 1'b0;
      frame_end_r   <= 1'b0;
    end else begin
      sel_d_r       <= sel_s;
      frame_start_r <= sel_s && !sel_d_r;
      frame_end_r   <= !sel_s && sel_d_r;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dev_active_r <= 1'b0;
    end else begin
      dev_active_r <= sel_s || embedded_busy;
    end
  end

  // Pad pull-up makes an open line read high, so protection is off
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_n_r <= 1'b1;
    end else begin
      wp_n_r <= lane_mode[1] ? 1'b1 : !line2_low_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Hardware reset sequencing
  qsp_rst_e rst_st_r;
  logic     reset_now_s;
  logic     hw_reset_r;
  logic     array_read_r;

  assign reset_now_s = rst_low_s
                     || (dq3_reset_en && line3_low_s && (!sel_s || !lane_mode[1]));

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_st_r <= QSP_RST_IDLE;
    end else begin
      case (rst_st_r)
        QSP_RST_IDLE:    rst_st_r <= reset_now_s ? QSP_RST_HELD : QSP_RST_IDLE;
        QSP_RST_HELD:    rst_st_r <= reset_now_s ? QSP_RST_HELD : QSP_RST_RECOVER;
        QSP_RST_RECOVER: rst_st_r <= reset_now_s ? QSP_RST_HELD : QSP_RST_IDLE;
        default:         rst_st_r <= QSP_RST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hw_reset_r   <= 1'b0;
      array_read_r <= 1'b0;
    end else begin
      hw_reset_r   <= reset_now_s;
      array_read_r <= (rst_st_r == QSP_RST_RECOVER) && !reset_now_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Received bytes to the core
  logic       sdr_seen_r;
  logic       ddr_seen_r;
  logic [7:0] rx_data_r;
  logic       rx_valid_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sdr_seen_r <= 1'b0;
      ddr_seen_r <= 1'b0;
      rx_data_r  <= '0;
      rx_valid_r <= 1'b0;
    end else begin
      sdr_seen_r <= sdr_tgl_s;
      ddr_seen_r <= ddr_tgl_s;
      rx_valid_r <= 1'b0;
      // Only a change of a link toggle announces a byte
      if (sdr_tgl_s != sdr_seen_r && sdr_tgl_s) begin
        rx_data_r  <= sdr_buf_r[1];
        rx_valid_r <= 1'b1;
      end else if (sdr_tgl_s != sdr_seen_r) begin
        rx_data_r  <= sdr_buf_r[0];
        rx_valid_r <= 1'b1;
      end else if (ddr_tgl_s != ddr_seen_r) begin
        rx_data_r  <= ddr_buf_r[ddr_tgl_s];
        rx_valid_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bytes from the core, buffered and handed to the link
  logic [7:0] fifo_data;
  logic       fifo_valid;
  logic       fifo_pop;
  logic       fifo_in_ready;
  logic       tx_ready_r;

  // Next byte only once the link has taken the previous one
  assign fifo_pop = fifo_valid && (tx_req_r == ack_s) && (rst_st_r == QSP_RST_IDLE);

  qsp_fifo #(.WIDTH(QSP_BYTE_W), .DEPTH(QSP_FIFO_DEPTH)) u_tx_fifo (
    .clk       (sys_clk),
    .arst_n    (arst_n),
    .flush     (rst_st_r == QSP_RST_HELD),
    .in_data   (tx_data),
    .in_valid  (tx_valid && tx_ready_r),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_hold_r <= '0;
      tx_req_r  <= 1'b0;
    end else if (fifo_pop) begin
      tx_hold_r <= fifo_data;
      tx_req_r  <= !tx_req_r;
    end
  end

  // Registered ready: one byte of slack beyond the FIFO is never needed
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_ready_r <= 1'b0;
    end else begin
      tx_ready_r <= fifo_in_ready && !(tx_valid && tx_ready_r) && (rst_st_r != QSP_RST_HELD);
    end
  end

  assign rx_data         = rx_data_r;
  assign rx_valid        = rx_valid_r;
  assign tx_ready        = tx_ready_r;
  assign dev_active      = dev_active_r;
  assign frame_start     = frame_start_r;
  assign frame_end       = frame_end_r;
  assign write_protect_n = wp_n_r;
  assign hw_reset        = hw_reset_r;
  assign array_read      = array_read_r;

endmodule // qsp_pin_if

//--- sim/qsp_pin_if_sva.sv
// Purpose: Concurrent checks on the ports of the quad serial pin interface.
// Assumes: Pins are watched as levels sampled on sys_clk.
// Notes:   Repetition counts cover the two to four cycle synchroniser lag.
`timescale 1ns/10ps
module qsp_pin_if_sva (
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       dev_sel_n,
  input wire logic [3:0] io_line_oe,
  input wire logic       reset_pin_n,
  input wire logic [1:0] lane_mode,
  input wire logic       read_phase,
  input wire logic       embedded_busy,
  input wire logic       rx_valid,
  input wire logic       dev_active,
  input wire logic       frame_start,
  input wire logic       frame_end,
  input wire logic       write_protect_n,
  input wire logic       hw_reset,
  input wire logic       array_read
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  AST_SEL_HIGHZ: assert property (dev_sel_n |-> io_line_oe == 4'h0)
    else $error("lines driven while deselected");
  AST_RST_HIGHZ: assert property (!reset_pin_n |-> io_line_oe == 4'h0)
    else $error("lines driven during reset");
  AST_OE_LEGAL: assert property (io_line_oe != 4'h0 |-> read_phase &&
    io_line_oe inside {4'h2, 4'h3, 4'hF}) else $error("bad drive pattern");
  AST_OE_QUAD: assert property (io_line_oe[3] |-> lane_mode[1])
    else $error("upper lines driven outside quad");
  AST_ACTIVE: assert property ((!dev_sel_n) [*5] |-> dev_active)
    else $error("selected but not active");
  AST_STANDBY: assert property ((dev_sel_n && !embedded_busy) [*5] |-> !dev_active)
    else $error("idle but still active");
  AST_BUSY: assert property (embedded_busy [*5] |-> dev_active)
    else $error("busy but not active");
  AST_HWRST: assert property ((!reset_pin_n) [*6] |-> hw_reset)
    else $error("reset pin not honoured");
  AST_WP_QUAD: assert property (lane_mode[1] [*5] |-> write_protect_n)
    else $error("protect asserted in quad");
  AST_FRAME: assert property (frame_start |-> !dev_sel_n && !frame_end)
    else $error("frame start without select");
  AST_FRAME_END: assert property (frame_end |-> dev_sel_n ##1 !frame_end)
    else $error("frame end without deselect");
  AST_ARRAY: assert property (array_read |=> !array_read && !rx_valid)
    else $error("array read not a pulse");
endmodule // qsp_pin_if_sva

bind qsp_pin_if qsp_pin_if_sva i_sva (.sys_clk(sys_clk), .arst_n(arst_n),
  .dev_sel_n(dev_sel_n), .io_line_oe(io_line_oe), .reset_pin_n(reset_pin_n),
  .lane_mode(lane_mode), .read_phase(read_phase), .embedded_busy(embedded_busy),
  .rx_valid(rx_valid), .dev_active(dev_active), .frame_start(frame_start),
  .frame_end(frame_end), .write_protect_n(write_protect_n), .hw_reset(hw_reset),
  .array_read(array_read));

//--- sim/qsp_host_model.sv
// Purpose: Behavioural host controller driving the serial pins.
// Assumes: Link clock 80 ns, mode 0, low while idle.
// Notes:   Data moves mid half-period so no edge race with the sampler.
`timescale 1ns/10ps
module qsp_host_model (
  output logic            serial_clock,
  output logic            dev_sel_n,
  output logic      [3:0] host_out,
  output logic      [3:0] host_oe,
  input  wire logic [3:0] io_line_in
);
  initial begin
    serial_clock = 1'b0;
    dev_sel_n = 1'b1;
    host_out = 4'h0;
    host_oe = 4'h0;
  end

  // Two edges first so the link side picks up the lane mode
  task automatic open_frame();
    #7;
    repeat (2) begin
      #40 serial_clock = 1'b1;
      #40 serial_clock = 1'b0;
    end
    #40 dev_sel_n = 1'b0;
    #40;
  endtask

  task automatic close_frame();
    #40 dev_sel_n = 1'b1;
    host_oe = 4'h0;
    #40;
  endtask

  task automatic drive_line(input int i, input logic v, input logic en);
    host_out[i] = v;
    host_oe[i] = en;
  endtask

  task automatic send_byte(input int w, input bit ddr, input logic [7:0] b, input int nb);
    host_oe = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
    if (ddr) begin
      host_out = b[7:4];
      #20 serial_clock = 1'b1;
      #20 host_out = b[3:0];
      #20 serial_clock = 1'b0;
      #100;
    end else begin
      for (int n = 8; n > 8 - nb; n -= w) begin
        host_out = 4'((b >> (n - w)) & 8'((1 << w) - 1));
        #20 serial_clock = 1'b1;
        #40 serial_clock = 1'b0;
        #20;
      end
    end
  endtask

  task automatic recv_bits(input int w, input bit ddr, output logic [7:0] b);
    host_oe = 4'h0;
    b = 8'h00;
    repeat (ddr ? 1 : 8 / w) begin
      #40 serial_clock = 1'b1;
      #40 serial_clock = 1'b0;
      #30;
      if (w == 1)
        b = {b[6:0], io_line_in[1]};
      else
        b = 8'(b << w) | 8'(io_line_in & 4'((1 << w) - 1));
      if (ddr) begin
        #10 serial_clock = 1'b1;
        #30 b = {b[3:0], io_line_in};
        #10 serial_clock = 1'b0;
      end
      #10;
    end
  endtask
endmodule // qsp_host_model

//--- sim/testbench.sv
// Purpose: Self-checking bench for the quad serial pin interface.
// Assumes: Host model owns the link; bench drives the core side on falling edges.
// Notes:   Released lines 0 and 1 toggle so stale data cannot pass.
`timescale 1ns/10ps
module testbench;
  import qsp_pkg::*;
  logic       sys_clk, arst_n, serial_clock, dev_sel_n, reset_pin_n, ddr_req, read_phase;
  logic       dq3_reset_en, embedded_busy, tx_valid, tx_ready, rx_valid, dev_active;
  logic       frame_start, frame_end, write_protect_n, hw_reset, array_read, float_bit;
  logic [1:0] lane_mode;
  logic [3:0] io_line_in, io_line_out, io_line_oe, host_out, host_oe;
  logic [7:0] rx_data, tx_data;
  logic [7:0] exp_q[$];
  int         err_count, cmp_count, seed, ar_seen;

  for (genvar i = 0; i < 4; i++) begin : g_wire
    assign io_line_in[i] = io_line_oe[i] ? io_line_out[i] : host_oe[i] ? host_out[i] :
                           (i >= 2) ? 1'b1 : float_bit;
  end

  qsp_pin_if i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .serial_clock(serial_clock),
    .dev_sel_n(dev_sel_n), .io_line_in(io_line_in), .io_line_out(io_line_out),
    .io_line_oe(io_line_oe), .reset_pin_n(reset_pin_n), .lane_mode(lane_mode),
    .ddr_req(ddr_req), .read_phase(read_phase), .dq3_reset_en(dq3_reset_en),
    .embedded_busy(embedded_busy), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .dev_active(dev_active),
    .frame_start(frame_start), .frame_end(frame_end), .write_protect_n(write_protect_n),
    .hw_reset(hw_reset), .array_read(array_read));
  qsp_host_model i_host (.serial_clock(serial_clock), .dev_sel_n(dev_sel_n),
    .host_out(host_out), .host_oe(host_oe), .io_line_in(io_line_in));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmp_flag(input string what, input logic exp, input logic seen);
    cmp_byte(what, {7'h00, exp}, {7'h00, seen});
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    float_bit <= ~float_bit;
    if (array_read === 1'b1)
      ar_seen++;
    if (rx_valid === 1'b1) begin
      cmp_flag("rx_expected", 1'b1, exp_q.size() > 0);
      if (exp_q.size() > 0)
        cmp_byte("rx_data", exp_q.pop_front(), rx_data);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic rx_frame(input int w, input bit ddr);
    logic [7:0] b;
    i_host.open_frame();
    repeat (3) begin
      b = 8'($random(seed));
      exp_q.push_back(b);
      i_host.send_byte(w, ddr, b, 8);
    end
    cmp_flag("dev_active", 1'b1, dev_active);
    i_host.close_frame();
    idle(10);
    cmp_flag("dev_active", 1'b0, dev_active);
    cmp_byte("rx_left", 8'h00, 8'(exp_q.size()));
    cmp_byte("oe_idle", 8'h00, {4'h0, io_line_oe});
  endtask

  task automatic tx_frame(input int w, input logic [7:0] b, input bit ddr);
    logic [7:0] seen;
    int         n;
    @(negedge sys_clk);
    tx_data = b;
    tx_valid = 1'b1;
    n = 0;
    while (tx_ready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    cmp_flag("tx_ready", 1'b1, tx_ready);
    @(negedge sys_clk);
    tx_valid = 1'b0;
    read_phase = 1'b1;
    idle(4);
    i_host.open_frame();
    i_host.recv_bits(w, ddr, seen);
    cmp_byte("oe_read", {4'h0, (w == 1) ? QSP_OE_SINGLE : (w == 2) ? QSP_OE_DUAL :
             QSP_OE_QUAD}, {4'h0, io_line_oe});
    cmp_byte("read_data", b, seen);
    i_host.close_frame();
    @(negedge sys_clk);
    read_phase = 1'b0;
    idle(10);
  endtask

  initial begin
    #400000;
    err_count++;
    finish_test();
  end

  initial begin
    logic [1:0] modes [5];
    int         w;
    modes = '{QSP_MODE_SINGLE, QSP_MODE_DUAL, QSP_QUAD_IO_MODE, QSP_QUAD_IO_MODE,
              QSP_QUAD_PERIPHERAL_MODE};
    seed = 75545;
    err_count = 0;
    cmp_count = 0;
    ar_seen = 0;
    float_bit = 1'b0;
    arst_n = 1'b0;
    reset_pin_n = 1'b1;
    lane_mode = QSP_MODE_SINGLE;
    ddr_req = 1'b0;
    read_phase = 1'b0;
    dq3_reset_en = 1'b0;
    embedded_busy = 1'b0;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    idle(2);
    arst_n = 1'b1;
    idle(2);
    cmp_byte("oe_reset", 8'h00, {4'h0, io_line_oe});
    cmp_flag("wp_open", 1'b1, write_protect_n);
    // Partial byte must vanish at deselect
    i_host.open_frame();
    i_host.send_byte(1, 1'b0, 8'hC3, 4);
    i_host.close_frame();
    idle(10);
    for (int m = 0; m < 5; m++) begin
      lane_mode = modes[m];
      ddr_req = (m == 1) || (m >= 3);
      w = (m == 0) ? 1 : (m == 1) ? 2 : 4;
      idle(2);
      rx_frame(w, ddr_req && lane_mode[1]);
    end
    for (int m = 0; m < 4; m++) begin
      lane_mode = modes[m];
      ddr_req = (m == 3);
      tx_frame((m == 3) ? 4 : 1 << m, (m == 0) ? 8'hA5 : 8'($random(seed)), m == 3);
    end
    ddr_req = 1'b0;
    lane_mode = QSP_MODE_SINGLE;
    i_host.open_frame();
    i_host.drive_line(2, 1'b0, 1'b1);
    idle(8);
    cmp_flag("wp_single", 1'b0, write_protect_n);
    i_host.close_frame();
    lane_mode = QSP_QUAD_IO_MODE;
    i_host.open_frame();
    i_host.drive_line(2, 1'b0, 1'b1);
    idle(8);
    cmp_flag("wp_quad", 1'b1, write_protect_n);
    i_host.close_frame();
    embedded_busy = 1'b1;
    idle(6);
    cmp_flag("busy_active", 1'b1, dev_active);
    embedded_busy = 1'b0;
    reset_pin_n = 1'b0;
    idle(6);
    cmp_flag("hw_reset_pin", 1'b1, hw_reset);
    cmp_byte("oe_in_reset", 8'h00, {4'h0, io_line_oe});
    ar_seen = 0;
    reset_pin_n = 1'b1;
    idle(12);
    cmp_byte("array_read", 8'h01, 8'(ar_seen));
    dq3_reset_en = 1'b1;
    lane_mode = QSP_MODE_SINGLE;
    i_host.drive_line(3, 1'b0, 1'b1);
    idle(6);
    cmp_flag("hw_reset_line3", 1'b1, hw_reset);
    i_host.drive_line(3, 1'b1, 1'b0);
    idle(12);
    lane_mode = QSP_QUAD_IO_MODE;
    i_host.open_frame();
    i_host.drive_line(3, 1'b0, 1'b1);
    idle(6);
    cmp_flag("line3_data_quad", 1'b0, hw_reset);
    i_host.close_frame();
    idle(6);
    finish_test();
  end
endmodule // testbench
